// *** src/emb_block.sv ***
// embedded memory block: input and output ports, shapes, clears
module emb_block
  import emb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_clk_pin,
  input wire logic out_clk_pin,
  input wire logic in_clk_en,
  input wire logic out_clk_en,
  input wire logic rd_clk_sel,
  input wire logic [1:0] shape_sel,
  input wire logic rom_mode,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [EMB_ADDR_W-1:0] wr_addr,
  input wire logic [EMB_ADDR_W-1:0] rd_addr,
  input wire logic [EMB_DATA_W-1:0] wr_data,
  input wire logic local_clr,
  input wire logic global_clr,
  output logic [EMB_DATA_W-1:0] rd_data
);

  emb_state_t st_q;
  emb_state_t st_d;
  logic clr;
  logic in_edge;
  logic out_edge;
  logic rd_edge;
  logic rd_ce;
  logic [EMB_DATA_W-1:0] rd_word;
  logic [EMB_OFF_W-1:0] rd_off;

  // ********************************************************************
  // side clocks
  // ********************************************************************
  // sampled side clocks: stage 0 only feeds stage 1
  assign in_edge = st_q.ic_s[1] & ~st_q.ic_s[2];
  assign out_edge = st_q.oc_s[1] & ~st_q.oc_s[2];
  assign rd_edge = rd_clk_sel ? out_edge : in_edge;
  assign rd_ce = rd_clk_sel ? out_clk_en : in_clk_en;
  assign clr = ~rst_n | local_clr | global_clr;
  assign rd_off = emb_bit_off(shape_sel, st_q.rd_addr);

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    st_d = st_q;
    st_d.ic_s = {st_q.ic_s[1:0], in_clk_pin};
    st_d.oc_s = {st_q.oc_s[1:0], out_clk_pin};
    st_d.wr_go = 1'b0;
    if (in_edge && in_clk_en) begin
      st_d.wr_go = wr_en & ~rom_mode;
      st_d.wr_idx = emb_word_idx(shape_sel, wr_addr);
      st_d.wr_mask = emb_lane(shape_sel)
                     << emb_bit_off(shape_sel, wr_addr);
      st_d.wr_word = emb_repl(shape_sel, wr_data);
    end
    if (rd_edge && rd_ce) begin
      st_d.rd_addr = rd_addr;
      st_d.rd_en = rd_en;
    end
    if (out_edge && out_clk_en && st_q.rd_en) begin
      st_d.q = (rd_word >> rd_off) & emb_lane(shape_sel);
    end
    if (clr) begin
      st_d.ic_s = EMB_SYNC_RST;
      st_d.oc_s = EMB_SYNC_RST;
      st_d.wr_go = 1'b0;
      st_d.wr_idx = EMB_IDX_RST;
      st_d.wr_mask = EMB_Q_RST;
      st_d.wr_word = EMB_Q_RST;
      st_d.rd_addr = EMB_ADDR_RST;
      st_d.rd_en = 1'b0;
      st_d.q = EMB_Q_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_q <= st_d;
  end

  assign rd_data = st_q.q;

  // ********************************************************************
  // storage
  // ********************************************************************
  // one word-wide array, wider or deeper memories tile blocks
  emb_store #(
    .WORDS(EMB_WORDS),
    .DW(EMB_DATA_W),
    .IW(EMB_IDX_W)
  ) u_store (
    .ref_clk(ref_clk),
    .wr_en(st_q.wr_go),
    .wr_idx(st_q.wr_idx),
    .wr_mask(st_q.wr_mask),
    .wr_word(st_q.wr_word),
    .rd_idx(emb_word_idx(shape_sel, st_q.rd_addr)),
    .rd_word(rd_word)
  );

  // ********************************************************************
  // checks
  // ********************************************************************
  // write arms only on an enabled input edge
  write_arm_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    in_edge && in_clk_en && wr_en && !rom_mode && !clr |=> st_q.wr_go)
    else $error("enabled write not armed");

  write_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(in_edge && in_clk_en) |=> !st_q.wr_go)
    else $error("write armed without enabled edge");

  rom_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rom_mode |=> !st_q.wr_go)
    else $error("write in rom use");

  rd_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_edge && rd_ce && !clr |=> st_q.rd_addr == $past(rd_addr))
    else $error("read address not captured");

  rd_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(rd_edge && rd_ce) && !clr |=> $stable(st_q.rd_addr))
    else $error("read address moved without edge");

  out_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(out_edge && out_clk_en && st_q.rd_en) && !clr |=> $stable(rd_data))
    else $error("output moved without enabled edge");

  // a held read keeps its earlier, possibly wider word
  narrow_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    out_edge && out_clk_en && st_q.rd_en && !clr
    && shape_sel == EMB_SHAPE_2048X2
    |=> rd_data[15:2] == 14'h0000)
    else $error("narrow read wider than lane");

  clear_all_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    local_clr || global_clr
    |=> rd_data == EMB_Q_RST && !st_q.wr_go && !st_q.rd_en)
    else $error("clear left a register set");

  write_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st_q.wr_go);
  read_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    out_edge && out_clk_en && st_q.rd_en && !clr);
  split_clk_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st_q.wr_go ##[1:20] rd_clk_sel && rd_edge && rd_ce);

endmodule // emb_block

// *** src/emb_pkg.sv ***
// shared constants, layouts and shape helpers of the embedded memory block
package emb_pkg;

  // ********************************************************************
  // geometry
  // ********************************************************************
  localparam int EMB_TOTAL_BITS = 4096;
  localparam int EMB_DATA_W = 16;
  localparam int EMB_ADDR_W = 11;
  localparam int EMB_IDX_W = 8;
  localparam int EMB_OFF_W = 4;
  localparam int EMB_WORDS = EMB_TOTAL_BITS / EMB_DATA_W;
  localparam int EMB_SYNC_W = 3;

  // ********************************************************************
  // shape codes
  // ********************************************************************
  localparam logic [1:0] EMB_SHAPE_256X16 = 2'h0;
  localparam logic [1:0] EMB_SHAPE_512X8 = 2'h1;
  localparam logic [1:0] EMB_SHAPE_1024X4 = 2'h2;
  localparam logic [1:0] EMB_SHAPE_2048X2 = 2'h3;

  localparam logic [15:0] EMB_LANE_16 = 16'hffff;
  localparam logic [15:0] EMB_LANE_8 = 16'h00ff;
  localparam logic [15:0] EMB_LANE_4 = 16'h000f;
  localparam logic [15:0] EMB_LANE_2 = 16'h0003;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [15:0] EMB_Q_RST = 16'h0000;
  localparam logic [10:0] EMB_ADDR_RST = 11'h000;
  localparam logic [7:0] EMB_IDX_RST = 8'h00;
  localparam logic [2:0] EMB_SYNC_RST = 3'h0;

  // ********************************************************************
  // state carrier
  // ********************************************************************
  typedef struct packed {
    logic [EMB_SYNC_W-1:0] ic_s;
    logic [EMB_SYNC_W-1:0] oc_s;
    logic wr_go;
    logic [EMB_IDX_W-1:0] wr_idx;
    logic [EMB_DATA_W-1:0] wr_mask;
    logic [EMB_DATA_W-1:0] wr_word;
    logic [EMB_ADDR_W-1:0] rd_addr;
    logic rd_en;
    logic [EMB_DATA_W-1:0] q;
  } emb_state_t;

  // ********************************************************************
  // shape helpers
  // ********************************************************************
  function automatic logic [7:0] emb_word_idx(logic [1:0] shp,
                                              logic [10:0] a);
    case (shp)
      EMB_SHAPE_256X16: emb_word_idx = a[7:0];
      EMB_SHAPE_512X8: emb_word_idx = a[8:1];
      EMB_SHAPE_1024X4: emb_word_idx = a[9:2];
      default: emb_word_idx = a[10:3];
    endcase
  endfunction

  function automatic logic [3:0] emb_bit_off(logic [1:0] shp,
                                             logic [10:0] a);
    case (shp)
      EMB_SHAPE_256X16: emb_bit_off = 4'h0;
      EMB_SHAPE_512X8: emb_bit_off = {a[0], 3'h0};
      EMB_SHAPE_1024X4: emb_bit_off = {a[1:0], 2'h0};
      default: emb_bit_off = {a[2:0], 1'h0};
    endcase
  endfunction

  function automatic logic [15:0] emb_lane(logic [1:0] shp);
    case (shp)
      EMB_SHAPE_256X16: emb_lane = EMB_LANE_16;
      EMB_SHAPE_512X8: emb_lane = EMB_LANE_8;
      EMB_SHAPE_1024X4: emb_lane = EMB_LANE_4;
      default: emb_lane = EMB_LANE_2;
    endcase
  endfunction

  function automatic logic [15:0] emb_repl(logic [1:0] shp,
                                           logic [15:0] d);
    case (shp)
      EMB_SHAPE_256X16: emb_repl = d;
      EMB_SHAPE_512X8: emb_repl = {2{d[7:0]}};
      EMB_SHAPE_1024X4: emb_repl = {4{d[3:0]}};
      default: emb_repl = {8{d[1:0]}};
    endcase
  endfunction

endpackage // emb_pkg

// *** src/emb_store.sv ***
// storage array of the embedded memory block with lane-masked writes
module emb_store
  import emb_pkg::*;
#(
  parameter int WORDS = EMB_WORDS,
  parameter int DW = EMB_DATA_W,
  parameter int IW = EMB_IDX_W
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [IW-1:0] wr_idx,
  input wire logic [DW-1:0] wr_mask,
  input wire logic [DW-1:0] wr_word,
  input wire logic [IW-1:0] rd_idx,
  output logic [DW-1:0] rd_word
);

  logic [DW-1:0] mem [WORDS];

  // ********************************************************************
  // array
  // ********************************************************************
  // contents survive clears, only the block's registers are cleared
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= (mem[wr_idx] & ~wr_mask) | (wr_word & wr_mask);
    end
  end

  assign rd_word = mem[rd_idx];

endmodule // emb_store

// *** testbench/emb_user.sv ***
// user logic model driving the side clocks of the memory block
module emb_user (
  input wire logic ref_clk,
  output logic in_clk_pin,
  output logic out_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial in_clk_pin = 1'b0;
  initial out_clk_pin = 1'b0;
  // one write side, one read side
  // side clocks stand low between frames; high 3, low 4 cycles
  task automatic tick(input bit side);
    @(posedge ref_clk);
    #2;
    if (side) out_clk_pin = 1'b1;
    else in_clk_pin = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2;
    if (side) out_clk_pin = 1'b0;
    else in_clk_pin = 1'b0;
    repeat (4) @(posedge ref_clk);
    #2;
  endtask
endmodule // emb_user

// *** testbench/tb_top.sv ***
// self-checking testbench of the embedded memory block
module tb_top
  import emb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n, in_clk_en, out_clk_en, rd_clk_sel, rom_mode;
  logic wr_en, rd_en, local_clr, global_clr, in_clk_pin, out_clk_pin;
  logic [1:0] shape_sel;
  logic [EMB_ADDR_W-1:0] wr_addr, rd_addr;
  logic [EMB_DATA_W-1:0] wr_data, rd_data, got;
  int miscompares = 0;
  int samples_checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  emb_user u_user (.ref_clk(ref_clk), .in_clk_pin(in_clk_pin),
    .out_clk_pin(out_clk_pin));
  emb_block dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .in_clk_pin(in_clk_pin), .out_clk_pin(out_clk_pin),
    .in_clk_en(in_clk_en), .out_clk_en(out_clk_en),
    .rd_clk_sel(rd_clk_sel), .shape_sel(shape_sel), .rom_mode(rom_mode),
    .wr_en(wr_en), .rd_en(rd_en), .wr_addr(wr_addr), .rd_addr(rd_addr),
    .wr_data(wr_data), .local_clr(local_clr), .global_clr(global_clr),
    .rd_data(rd_data));
  // ********************************************************************
  // helpers
  // ********************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [15:0] d,
                    input logic we);
    wr_addr = a;
    wr_data = d;
    wr_en = we;
    u_user.tick(1'b0);
    wr_en = 1'b0;
    // released data is not left showing the last value
    wr_data = ~d;
  endtask
  // data lags address capture by one output-side edge
  task automatic rd(input logic [10:0] a, output logic [15:0] q);
    rd_addr = a;
    rd_en = 1'b1;
    u_user.tick(rd_clk_sel);
    u_user.tick(1'b1);
    q = rd_data;
  endtask
  function automatic logic [15:0] pat(input int i, input int s);
    return 16'h5a3c ^ 16'(i * 16'h1111 + s);
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ********************************************************************
  // scenarios
  // ********************************************************************
  task automatic t_shapes();
    logic [10:0] a[3];
    logic [15:0] lane;
    for (int s = 0; s < 4; s++) begin
      shape_sel = s[1:0];
      lane = 16'hffff >> (16 - (16 >> s));
      // narrow lanes share one word: neighbours must survive
      a = '{11'h020, 11'h021, 11'((256 << s) - 1)};
      for (int i = 0; i < 3; i++) wr(a[i], pat(i, s), 1'b1);
      for (int i = 0; i < 3; i++) begin
        rd(a[i], got);
        chk(got, pat(i, s) & lane);
      end
    end
    $display("test shapes done");
  endtask
  task automatic t_gate();
    shape_sel = EMB_SHAPE_256X16;
    rd_clk_sel = 1'b0;
    wr(11'h033, 16'h1001, 1'b1);
    wr(11'h033, 16'h2002, 1'b0);
    in_clk_en = 1'b0;
    wr(11'h033, 16'h3003, 1'b1);
    in_clk_en = 1'b1;
    rom_mode = 1'b1;
    wr(11'h033, 16'h4004, 1'b1);
    rom_mode = 1'b0;
    rd(11'h033, got);
    chk(got, 16'h1001);
    $display("test write gating done");
  endtask
  task automatic t_read();
    wr(11'h040, 16'hc0de, 1'b1);
    wr(11'h041, 16'hfeed, 1'b1);
    rd_clk_sel = 1'b1;
    rd(11'h040, got);
    chk(got, 16'hc0de);
    rd_addr = 11'h041;
    rd_en = 1'b0;
    u_user.tick(1'b1);
    u_user.tick(1'b1);
    chk(rd_data, 16'hc0de);
    // address taken on the input side, output edge gated off
    rd_en = 1'b1;
    rd_clk_sel = 1'b0;
    out_clk_en = 1'b0;
    u_user.tick(1'b0);
    u_user.tick(1'b1);
    chk(rd_data, 16'hc0de);
    out_clk_en = 1'b1;
    u_user.tick(1'b1);
    chk(rd_data, 16'hfeed);
    rd_clk_sel = 1'b1;
    rd(11'h041, got);
    chk(got, 16'hfeed);
    $display("test read side done");
  endtask
  task automatic t_clear();
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      #2;
      local_clr = (k == 0);
      global_clr = (k == 1);
      rst_n = (k != 2);
      @(posedge ref_clk);
      #2;
      local_clr = 1'b0;
      global_clr = 1'b0;
      rst_n = 1'b1;
      chk(rd_data, EMB_Q_RST);
      // the array itself keeps its contents
      rd(11'h041, got);
      chk(got, 16'hfeed);
    end
    $display("test clears done");
  endtask
  initial begin
    rst_n = 1'b0;
    local_clr = 1'b0;
    global_clr = 1'b0;
    rom_mode = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    rd_clk_sel = 1'b0;
    in_clk_en = 1'b1;
    out_clk_en = 1'b1;
    shape_sel = EMB_SHAPE_256X16;
    wr_addr = '0;
    rd_addr = '0;
    wr_data = '0;
    repeat (12) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    chk(rd_data, EMB_Q_RST);
    t_shapes();
    t_gate();
    t_read();
    t_clear();
    summarize();
  end
  // runs take about 500 cycles; cut a hang well beyond that
  initial begin
    repeat (6000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end
endmodule // tb_top
